//--- design/ird_pkg.sv
// What this block does
// - test strobe write fires selected input enable
// - sync strobe write gives one-clock pulse
// - sync path tolerates two external pipeline stages
// - order slot holds channel and type selector
// - types 0-3 give I and Q halves
// - types 4-7 give magnitude, phase, gain
// - read address at direct 3 picks source
// - read address write fetches or freezes source
// - unstrobed sources read live at direct 0/1
// - gain sample comes from separate indirect write
// - channel nibble 0-3 or F only valid
// - carrier, wait and timing values readable per channel
// - memory ranges readable per channel
// - level detector output readable globally
// - test word feeds inputs, enable level or strobe
package ird_pkg;
    localparam int NUM_CHAN = 4;
    localparam int SLOTS = 32;
    localparam logic [2:0] DIR_DATA_LO = 3'h0;
    localparam logic [2:0] DIR_DATA_HI = 3'h1;
    localparam logic [2:0] DIR_RD_ADDR = 3'h3;
    localparam logic [2:0] DIR_WR_ADDR = 3'h4;
    localparam logic [7:0] GLOBAL_PAGE = 8'hF8;
    localparam logic [15:0] GA_LEVEL_DET = 16'hF806;
    localparam logic [15:0] GA_TEST_WORD = 16'hF807;
    localparam logic [15:0] GA_TEST_STB = 16'hF808;
    localparam logic [15:0] GA_SYNC_STB = 16'hF809;
    localparam logic [15:0] GA_ORDER_LO = 16'hF820;
    localparam logic [15:0] GA_ORDER_HI = 16'hF83F;
    localparam logic [3:0] CHAN_BCAST = 4'hF;
    localparam logic [11:0] IA_CHAN_CFG = 12'h000;
    localparam logic [11:0] IA_CARRIER = 12'h006;
    localparam logic [11:0] IA_TIMING = 12'h009;
    localparam logic [11:0] IA_WAIT = 12'h00C;
    localparam logic [11:0] IA_AGC = 12'h00F;
    localparam logic [11:0] IA_INSTR_LO = 12'h100;
    localparam logic [11:0] IA_INSTR_HI = 12'h1FC;
    localparam logic [11:0] IA_COEF_LO = 12'h400;
    localparam logic [11:0] IA_COEF_HI = 12'h5FF;
    localparam int CFG_INEN_LEVEL_BIT = 11;
    localparam int CFG_INEN_SEL_BIT = 12;
    localparam logic [2:0] DT_I_HI = 3'h0;
    localparam logic [2:0] DT_I_LO = 3'h1;
    localparam logic [2:0] DT_Q_HI = 3'h2;
    localparam logic [2:0] DT_Q_LO = 3'h3;
    localparam logic [2:0] DT_MAG_HI = 3'h4;
    localparam logic [2:0] DT_MAG_LO = 3'h5;
    localparam logic [2:0] DT_PHASE = 3'h6;
    localparam logic [2:0] DT_GAIN = 3'h7;
    localparam logic [7:0] PAD_ZERO = 8'h00;
    localparam logic [15:0] HALF_ZERO = 16'h0000;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    typedef struct packed {
        logic [23:0] i_path;
        logic [23:0] q_path;
        logic [23:0] mag;
        logic [15:0] phase;
        logic [15:0] agc_gain;
        logic [31:0] carrier_freq;
        logic [31:0] timing_freq;
        logic [31:0] wait_vals;
    } ird_chan_s;

    typedef struct packed {
        logic ce_n;
        logic wr_n;
        logic rd_n;
        logic [2:0] addr;
        logic [15:0] data;
    } ird_bus_s;

    typedef struct packed {
        logic strobe;
        logic [1:0] chan;
        logic [11:0] addr;
    } ird_mem_req_s;

    typedef struct packed {
        logic [1:0] channel_field;
        logic [2:0] data_type_field;
    } ird_sel_s;
endpackage

//--- design/ird_order_sel.sv
`timescale 1ns/10ps
`default_nettype none
module ird_order_sel
    import ird_pkg::*;
(
    input wire ird_sel_s i_sel,
    input wire ird_chan_s i_chans [NUM_CHAN],
    output logic [15:0] o_word
);
    ird_chan_s ch;

    always_comb
    begin
        ch = i_chans[i_sel.channel_field];
        unique case (i_sel.data_type_field)
            DT_I_HI: o_word = ch.i_path[23:8];
            DT_I_LO: o_word = {ch.i_path[7:0], PAD_ZERO};
            DT_Q_HI: o_word = ch.q_path[23:8];
            DT_Q_LO: o_word = {ch.q_path[7:0], PAD_ZERO};
            DT_MAG_HI: o_word = ch.mag[23:8];
            DT_MAG_LO: o_word = {ch.mag[7:0], PAD_ZERO};
            DT_PHASE: o_word = ch.phase;
            DT_GAIN: o_word = ch.agc_gain;
        endcase
    end
endmodule
`default_nettype wire

//--- design/ird_regs.sv
`timescale 1ns/10ps
`default_nettype none
module ird_regs
    import ird_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire ird_bus_s i_bus,
    output logic [15:0] o_bus_rdata,
    output logic o_bus_oe,
    input wire ird_chan_s i_chans [NUM_CHAN],
    input wire logic [31:0] i_level_det,
    input wire logic [31:0] i_mem_rdata,
    output ird_mem_req_s o_mem_req,
    input wire logic i_sync_in_pin,
    output logic o_sync_out_pin,
    output logic o_sync_in_pulse,
    input wire logic [4:0] i_slot_idx,
    output logic [15:0] o_slot_word,
    output logic [15:0] o_test_word,
    output logic [NUM_CHAN-1:0] o_input_enable_strobe
);
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    ird_bus_s bus_s1_q;
    ird_bus_s bus_s2_q;
    ird_bus_s bus_p_q;
    logic sync_s1_q;
    logic sync_s2_q;
    logic sync_p_q;

    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            bus_s1_q <= '{ce_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, default: '0};
            bus_s2_q <= '{ce_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, default: '0};
            bus_p_q <= '{ce_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, default: '0};
        end
        else
        begin
            bus_s1_q <= i_bus;
            bus_s2_q <= bus_s1_q;
            bus_p_q <= bus_s2_q;
        end
    end

    // ----------------------------------------
    // write decode
    // ----------------------------------------
    logic wr_commit;
    logic [2:0] wr_dir;
    logic [15:0] wr_val;
    logic gwr;
    logic iwr;
    logic [15:0] waddr;
    logic [3:0] wnib;
    logic [11:0] woff;
    logic [15:0] hold_q;

    // write completes on the rising wr edge, chip selected
    assign wr_commit = ~bus_p_q.wr_n & bus_s2_q.wr_n & ~bus_p_q.ce_n;
    assign wr_dir = bus_p_q.addr;
    assign wr_val = bus_p_q.data;
    assign waddr = wr_val;
    assign wnib = waddr[15:12];
    assign woff = waddr[11:0];
    assign gwr = wr_commit && wr_dir == DIR_WR_ADDR && waddr[15:8] == GLOBAL_PAGE;
    assign iwr = wr_commit && wr_dir == DIR_WR_ADDR && waddr[15:8] != GLOBAL_PAGE;

    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            hold_q <= HALF_ZERO;
        else if (wr_commit && wr_dir == DIR_DATA_LO)
            hold_q <= wr_val;
    end

    // ----------------------------------------
    // global strobes and test word
    // ----------------------------------------
    logic test_stb_q;
    logic sync_out_q;
    logic [15:0] test_word_q;

    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            test_stb_q <= 1'b0;
            sync_out_q <= 1'b0;
        end
        else
        begin
            test_stb_q <= gwr && waddr == GA_TEST_STB;
            sync_out_q <= gwr && waddr == GA_SYNC_STB;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            test_word_q <= HALF_ZERO;
        else if (gwr && waddr == GA_TEST_WORD)
            test_word_q <= hold_q;
    end

    // ----------------------------------------
    // read order table
    // ----------------------------------------
    ird_sel_s order_q [SLOTS];
    logic [15:0] slot_word;
    logic [15:0] slot_word_q;

    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            order_q <= '{default: '0};
        else if (gwr && waddr >= GA_ORDER_LO && waddr <= GA_ORDER_HI)
            order_q[waddr[4:0]] <= hold_q[4:0];
    end

    ird_order_sel u_sel (
        .i_sel(order_q[i_slot_idx]),
        .i_chans(i_chans),
        .o_word(slot_word)
    );

    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            slot_word_q <= HALF_ZERO;
        else
            slot_word_q <= slot_word;
    end

    // ----------------------------------------
    // per channel config and gain sample
    // ----------------------------------------
    logic [NUM_CHAN-1:0] inen_lvl_q;
    logic [NUM_CHAN-1:0] inen_sel_q;
    logic [NUM_CHAN-1:0] enable_q;
    logic [15:0] agc_hold_q [NUM_CHAN];

    genvar c;
    generate
        for (c = 0; c < NUM_CHAN; c++)
        begin : g_chan
            logic hit;
            assign hit = iwr && (wnib == 4'(c) || wnib == CHAN_BCAST);

            always_ff @(posedge i_ref_clk or negedge i_resetn)
            begin
                if (!i_resetn)
                begin
                    inen_lvl_q[c] <= 1'b0;
                    inen_sel_q[c] <= 1'b0;
                end
                else if (hit && woff == IA_CHAN_CFG)
                begin
                    inen_lvl_q[c] <= hold_q[CFG_INEN_LEVEL_BIT];
                    inen_sel_q[c] <= hold_q[CFG_INEN_SEL_BIT];
                end
            end

            // gain sampled by its own write
            always_ff @(posedge i_ref_clk or negedge i_resetn)
            begin
                if (!i_resetn)
                    agc_hold_q[c] <= HALF_ZERO;
                else if (hit && woff == IA_AGC)
                    agc_hold_q[c] <= i_chans[c].agc_gain;
            end

            always_ff @(posedge i_ref_clk or negedge i_resetn)
            begin
                if (!i_resetn)
                    enable_q[c] <= 1'b0;
                else
                    enable_q[c] <= inen_sel_q[c] ? test_stb_q : inen_lvl_q[c];
            end
        end
    endgenerate

    // ----------------------------------------
    // read address and fetch
    // ----------------------------------------
    logic rd_addr_wr;
    logic [15:0] rd_addr_q;
    logic [3:0] rnib;
    logic [11:0] roff;
    logic r_glob;
    logic r_chan_ok;
    logic [1:0] r_chan;
    logic w_mem;
    logic w_glob;
    ird_mem_req_s mem_req_q;
    logic mem_pend_q;
    logic [31:0] snap_q;

    assign rd_addr_wr = wr_commit && wr_dir == DIR_RD_ADDR;
    assign w_glob = wr_val[15:8] == GLOBAL_PAGE;
    assign w_mem = !w_glob && (wr_val[15:12] < 4'(NUM_CHAN) || wr_val[15:12] == CHAN_BCAST)
        && ((wr_val[11:0] >= IA_INSTR_LO && wr_val[11:0] <= IA_INSTR_HI)
        || (wr_val[11:0] >= IA_COEF_LO && wr_val[11:0] <= IA_COEF_HI));

    // direct 3 holds the read address
    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            rd_addr_q <= HALF_ZERO;
        else if (rd_addr_wr)
            rd_addr_q <= wr_val;
    end

    // each fresh read needs a new strobe
    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            mem_req_q <= '0;
            mem_pend_q <= 1'b0;
        end
        else
        begin
            mem_req_q.strobe <= rd_addr_wr && w_mem;
            mem_pend_q <= mem_req_q.strobe;
            if (rd_addr_wr)
            begin
                mem_req_q.chan <= wr_val[13:12];
                mem_req_q.addr <= wr_val[11:0];
            end
        end
    end

    // freeze level output or memory word
    // level detector captured at address write
    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            snap_q <= WORD_ZERO;
        else if (rd_addr_wr && wr_val == GA_LEVEL_DET)
            snap_q <= i_level_det;
        else if (mem_pend_q)
            snap_q <= i_mem_rdata;
    end

    // ----------------------------------------
    // read source mux
    // ----------------------------------------
    logic [31:0] rd_word;
    logic [31:0] rd_word_q;
    ird_chan_s rch;

    assign rnib = rd_addr_q[15:12];
    assign roff = rd_addr_q[11:0];
    assign r_glob = rd_addr_q[15:8] == GLOBAL_PAGE;
    assign r_chan_ok = rnib < 4'(NUM_CHAN) || rnib == CHAN_BCAST;
    assign r_chan = rnib == CHAN_BCAST ? 2'h0 : rnib[1:0];
    assign rch = i_chans[r_chan];

    always_comb
    begin
        rd_word = WORD_ZERO;
        if (r_glob)
        begin
            if (rd_addr_q == GA_LEVEL_DET)
                rd_word = snap_q;
            else if (rd_addr_q == GA_TEST_WORD)
                rd_word = {HALF_ZERO, test_word_q};
            else if (rd_addr_q >= GA_ORDER_LO && rd_addr_q <= GA_ORDER_HI)
                rd_word = {27'h0, order_q[rd_addr_q[4:0]]};
        end
        else if (r_chan_ok)
        begin
            if (roff == IA_CARRIER)
                rd_word = rch.carrier_freq;
            else if (roff == IA_WAIT)
                rd_word = rch.wait_vals;
            else if (roff == IA_TIMING)
                rd_word = rch.timing_freq;
            else if (roff == IA_AGC)
                rd_word = {HALF_ZERO, agc_hold_q[r_chan]};
            else if ((roff >= IA_INSTR_LO && roff <= IA_INSTR_HI)
                || (roff >= IA_COEF_LO && roff <= IA_COEF_HI))
                rd_word = snap_q;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            rd_word_q <= WORD_ZERO;
        else
            rd_word_q <= rd_word;
    end

    // ----------------------------------------
    // read data pins
    // ----------------------------------------
    logic [15:0] rdata_q;
    logic oe_q;

    // direct 0 low half, direct 1 high half
    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            rdata_q <= HALF_ZERO;
            oe_q <= 1'b0;
        end
        else
        begin
            oe_q <= ~bus_s2_q.ce_n & ~bus_s2_q.rd_n;
            if (bus_s2_q.addr == DIR_DATA_LO)
                rdata_q <= rd_word_q[15:0];
            else if (bus_s2_q.addr == DIR_DATA_HI)
                rdata_q <= rd_word_q[31:16];
            else
                rdata_q <= HALF_ZERO;
        end
    end

    // ----------------------------------------
    // sync input
    // ----------------------------------------
    logic sync_in_q;

    // external stages only delay the pulse
    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            sync_s1_q <= 1'b0;
            sync_s2_q <= 1'b0;
            sync_p_q <= 1'b0;
            sync_in_q <= 1'b0;
        end
        else
        begin
            sync_s1_q <= i_sync_in_pin;
            sync_s2_q <= sync_s1_q;
            sync_p_q <= sync_s2_q;
            sync_in_q <= sync_s2_q & ~sync_p_q;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign o_bus_rdata = rdata_q;
    assign o_bus_oe = oe_q;
    assign o_mem_req = mem_req_q;
    assign o_sync_out_pin = sync_out_q;
    assign o_sync_in_pulse = sync_in_q;
    assign o_slot_word = slot_word_q;
    assign o_test_word = test_word_q;
    assign o_input_enable_strobe = enable_q;
endmodule
`default_nettype wire

//--- test/ird_regs_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module ird_regs_checker
    import ird_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire ird_bus_s i_bus,
    input wire logic [15:0] o_bus_rdata,
    input wire logic o_bus_oe,
    input wire ird_mem_req_s o_mem_req,
    input wire logic o_sync_out_pin,
    input wire logic [15:0] o_test_word,
    input wire logic [NUM_CHAN-1:0] o_input_enable_strobe
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_resetn);

    // ------------------------------
    // bus pin sequences
    // ------------------------------
    sequence read_held;
        (!i_bus.ce_n && !i_bus.rd_n) [*4];
    endsequence
    sequence read_idle;
        i_bus.rd_n [*4];
    endsequence
    sequence bad_read_held;
        (!i_bus.ce_n && !i_bus.rd_n && i_bus.addr == 3'h2) [*4];
    endsequence
    sequence write_released;
        $past(i_bus.wr_n) && $past(i_bus.wr_n, 2);
    endsequence

    read_drive_a: assert property (read_held |-> o_bus_oe)
        else $error("bus not driven during held read");
    read_release_a: assert property (read_idle |-> !o_bus_oe)
        else $error("bus driven while no read");
    bad_direct_a: assert property (bad_read_held |-> o_bus_rdata == 16'h0000)
        else $error("unmapped direct address read nonzero");
    sync_width_a: assert property ($rose(o_sync_out_pin) |=> !o_sync_out_pin)
        else $error("sync pulse wider than one clock");
    sync_cause_a: assert property ($rose(o_sync_out_pin) |-> write_released)
        else $error("sync pulse without finished write");
    fetch_width_a: assert property (o_mem_req.strobe |=> !o_mem_req.strobe)
        else $error("fetch strobe wider than one clock");
    fetch_range_a: assert property (o_mem_req.strobe |->
        o_mem_req.addr inside {[IA_INSTR_LO:IA_INSTR_HI], [IA_COEF_LO:IA_COEF_HI]})
        else $error("fetch strobe outside memory ranges");
    test_word_a: assert property ($changed(o_test_word) |-> write_released)
        else $error("test word changed without write");
    enable_cause_a: assert property ($rose(|o_input_enable_strobe) |-> write_released)
        else $error("input enable rose without write");
endmodule

bind ird_regs ird_regs_checker u_chk (.i_ref_clk, .i_resetn, .i_bus, .o_bus_rdata, .o_bus_oe,
    .o_mem_req, .o_sync_out_pin, .o_test_word, .o_input_enable_strobe);
`default_nettype wire

//--- test/ird_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module ird_host_model
    import ird_pkg::*;
(
    input wire logic i_clk,
    input wire logic [15:0] i_rdata,
    output var ird_bus_s o_bus
);
    initial o_bus = '{1'b1, 1'b1, 1'b1, 3'h0, 16'h0000};

    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    // long low and high phases for the pin synchroniser
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        cyc(1);
        o_bus = '{1'b0, 1'b0, 1'b1, a, d};
        cyc(3);
        o_bus.wr_n = 1'b1;
        cyc(3);
        o_bus.ce_n = 1'b1;
        o_bus.data = ~d;
        cyc(3);
    endtask

    task automatic rd(input logic [2:0] a, output logic [15:0] v);
        cyc(1);
        o_bus = '{1'b0, 1'b1, 1'b0, a, ~o_bus.data};
        cyc(5);
        v = i_rdata;
        o_bus.rd_n = 1'b1;
        o_bus.ce_n = 1'b1;
        cyc(4);
    endtask

    task automatic rd32(output logic [31:0] v);
        logic [15:0] lo;
        logic [15:0] hi;
        rd(DIR_DATA_LO, lo);
        rd(DIR_DATA_HI, hi);
        v = {hi, lo};
    endtask
endmodule
`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import ird_pkg::*;
();
    logic clk = 1'b0;
    logic rstn = 1'b0;
    ird_bus_s bus;
    logic [15:0] rdata;
    logic [15:0] slot_word;
    logic [15:0] test_word;
    logic oe;
    logic sync_out;
    logic in_pulse;
    logic sp1 = 1'b0;
    logic sp2 = 1'b0;
    ird_chan_s chans [NUM_CHAN];
    logic [31:0] level_det = 32'h0;
    logic [31:0] mem_rdata = 32'h0;
    logic mem_ack = 1'b0;
    ird_mem_req_s mem_req;
    logic [4:0] slot_idx = 5'h0;
    logic [3:0] ies;
    int n_mismatch = 0;
    int total_checks = 0;
    int cycles = 0;
    int n_sync = 0;
    int n_in = 0;
    int n_ies = 0;
    int n_stb = 0;

    ird_regs dut (.i_ref_clk(clk), .i_resetn(rstn), .i_bus(bus), .o_bus_rdata(rdata), .o_bus_oe(oe),
        .i_chans(chans), .i_level_det(level_det), .i_mem_rdata(mem_rdata), .o_mem_req(mem_req),
        .i_sync_in_pin(sp2), .o_sync_out_pin(sync_out), .o_sync_in_pulse(in_pulse),
        .i_slot_idx(slot_idx), .o_slot_word(slot_word), .o_test_word(test_word),
        .o_input_enable_strobe(ies));
    ird_host_model host (.i_clk(clk), .i_rdata(rdata), .o_bus(bus));

    initial
    begin
        forever #20 clk = ~clk;
    end

    // ------------------------------
    // far side: two sync stages, memory
    // ------------------------------
    always @(negedge clk)
    begin
        sp1 <= sync_out;
        sp2 <= sp1;
        // word stands through the cycle after the fetch strobe
        mem_ack <= mem_req.strobe;
        mem_rdata <= mem_ack ? {8'hE0, 6'h0, mem_req.chan, 4'h0, mem_req.addr} : ~mem_rdata;
    end

    always @(posedge clk)
    begin
        cycles++;
        n_sync += sync_out;
        n_in += in_pulse;
        n_ies += ies[1];
        n_stb += mem_req.strobe;
        if (cycles == 20000)
        begin
            n_mismatch++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic gw(input logic [15:0] a, input logic [15:0] d);
        host.wr(DIR_DATA_LO, d);
        host.wr(DIR_WR_ADDR, a);
    endtask

    function automatic logic [15:0] exp_word(input ird_chan_s c, input logic [2:0] t);
        case (t)
            3'h0: return c.i_path[23:8];
            3'h1: return {c.i_path[7:0], 8'h00};
            3'h2: return c.q_path[23:8];
            3'h3: return {c.q_path[7:0], 8'h00};
            3'h4: return c.mag[23:8];
            3'h5: return {c.mag[7:0], 8'h00};
            3'h6: return c.phase;
            default: return c.agc_gain;
        endcase
    endfunction

    // ------------------------------
    // scenarios
    // ------------------------------
    task automatic t_sync();
        n_sync = 0;
        n_in = 0;
        gw(GA_SYNC_STB, 16'hFFFF);
        host.cyc(8);
        chk(n_sync, 1);
        chk(n_in, 1);
        $display("sync test done");
    endtask

    task automatic t_order();
        logic [4:0] s;
        for (int t = 0; t < 8; t++)
        begin
            s = 5'(t * 4 + 3);
            gw(GA_ORDER_LO + 16'(s), {11'h0, t[1:0], t[2:0]});
            slot_idx = s;
            host.cyc(2);
            chk(slot_word, exp_word(chans[t % 4], t[2:0]));
        end
        $display("order test done");
    endtask

    task automatic t_strobe();
        gw(16'h1000, 16'h1000);
        n_ies = 0;
        host.wr(DIR_WR_ADDR, GA_TEST_STB);
        host.cyc(4);
        chk(n_ies, 1);
        chk(ies, 4'h0);
        gw(16'h1000, 16'h0800);
        host.cyc(4);
        chk(ies, 4'h2);
        gw(GA_TEST_WORD, 16'h5A5A);
        chk(test_word, 16'h5A5A);
        $display("strobe test done");
    endtask

    task automatic t_read();
        logic [31:0] v;
        logic [15:0] w;
        logic [15:0] g;
        logic [11:0] offs [3] = '{IA_CARRIER, IA_TIMING, IA_WAIT};
        for (int k = 0; k < 3; k++)
        begin
            host.wr(DIR_RD_ADDR, {4'h2, offs[k]});
            host.rd32(v);
            chk(v, k == 0 ? chans[2].carrier_freq : k == 1 ? chans[2].timing_freq : chans[2].wait_vals);
        end
        chans[2].wait_vals = 32'h0BAD_F00D;
        host.rd32(v);
        chk(v, 32'h0BAD_F00D);
        host.rd(3'h2, w);
        chk(w, 16'h0000);
        n_stb = 0;
        host.wr(DIR_RD_ADDR, 16'h3140);
        host.rd32(v);
        chk(v, 32'hE003_0140);
        host.wr(DIR_RD_ADDR, 16'h5140);
        host.cyc(4);
        chk(n_stb, 1);
        level_det = 32'h00AB_CDEF;
        host.wr(DIR_RD_ADDR, GA_LEVEL_DET);
        level_det = 32'h0;
        host.rd32(v);
        chk(v, 32'h00AB_CDEF);
        g = chans[2].agc_gain;
        host.wr(DIR_WR_ADDR, 16'h200F);
        chans[2].agc_gain = 16'hFACE;
        host.wr(DIR_RD_ADDR, 16'h200F);
        host.rd32(v);
        chk(v, {16'h0000, g});
        g = chans[3].agc_gain;
        host.wr(DIR_WR_ADDR, 16'hF00F);
        chans[3].agc_gain = 16'h0BEE;
        host.wr(DIR_RD_ADDR, 16'h300F);
        host.rd32(v);
        chk(v, {16'h0000, g});
        host.wr(DIR_RD_ADDR, 16'hF006);
        host.rd32(v);
        chk(v, chans[0].carrier_freq);
        $display("read test done");
    endtask

    initial
    begin
        for (int k = 0; k < NUM_CHAN; k++)
            chans[k] = '{24'h1234A5 + k, 24'h6789B6 + k, 24'hCDEF17 + k, 16'h2468 + k,
                16'h1357 + k, 32'hC0DE0000 + k, 32'h71A10000 + k, 32'h3A170000 + k};
        repeat (12) @(negedge clk);
        rstn = 1'b1;
        t_sync();
        t_order();
        t_strobe();
        t_read();
        report_and_stop();
    end
endmodule
`default_nettype wire
